// *** src/fdp_pkg.sv ***
// Constants, types and byte table for the discovery parameter ROM.
// Assumes the caller decodes the table region and presents byte offsets.

package fdp_pkg;

  // First byte of this slice in each address layout
  localparam logic [7:0] FDP_QUERY_BASE = 8'h0e;
  localparam logic [7:0] FDP_DISC_BASE  = 8'h0c;
  localparam int         FDP_ENTRIES    = 24;
  localparam logic [7:0] FDP_ENTRY_CNT  = 8'h18;

  // Entry whose value depends on the latency mode
  localparam int         FDP_DUAL_IO_ENTRY = 2;
  localparam logic [7:0] FDP_DUAL_IO_STD   = 8'h04;
  localparam logic [7:0] FDP_DUAL_IO_ENH   = 8'h80;

  // Individual values
  localparam logic [7:0] FDP_DUAL_OUT_CFG = 8'h08;
  localparam logic [7:0] FDP_DUAL_OUT_OP  = 8'h3b;
  localparam logic [7:0] FDP_DUAL_IO_OP   = 8'hbb;
  localparam logic [7:0] FDP_ALL_MODES    = 8'hee;
  localparam logic [7:0] FDP_FILL         = 8'hff;
  localparam logic [7:0] FDP_QUAD_ALL_CFG = 8'heb;
  localparam logic [7:0] FDP_QUAD_ALL_OP  = 8'h00;
  localparam logic [7:0] FDP_NO_SIZE      = 8'h00;
  localparam logic [7:0] FDP_ERASE3_SIZE  = 8'h12;
  localparam logic [7:0] FDP_ERASE3_OP    = 8'hd8;

  // Output values after reset
  localparam logic [7:0] FDP_RST_DATA = 8'h00;

  // Table in order of rising offset; entry 2 is replaced by the latency mux
  localparam logic [0:FDP_ENTRIES-1][7:0] FDP_TABLE = {
    FDP_DUAL_OUT_CFG, FDP_DUAL_OUT_OP, FDP_DUAL_IO_STD, FDP_DUAL_IO_OP,
    FDP_ALL_MODES, FDP_FILL, FDP_FILL, FDP_FILL,
    FDP_FILL, FDP_FILL, FDP_FILL, FDP_FILL,
    FDP_FILL, FDP_FILL, FDP_FILL, FDP_QUAD_ALL_CFG,
    FDP_QUAD_ALL_OP, FDP_FILL, FDP_NO_SIZE, FDP_FILL,
    FDP_ERASE3_SIZE, FDP_ERASE3_OP, FDP_NO_SIZE, FDP_FILL
  };

  // One access from the serial front end
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       querySpace;
    logic [7:0] addr;
    logic [7:0] wrData;
  } fdp_req_t;

endpackage

// *** src/fdp_param_rom.sv ***
// Discovery parameter ROM slice: dual read, mode support and erase types.
// Assumes requests come from logic on the same clock; one answer per read.
`timescale 1ns/1ps
`default_nettype none

module fdp_param_rom (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire fdp_pkg::fdp_req_t req,
  input  wire logic             enhancedFastLatencyMode,
  output var  logic [7:0]       rdData,
  output var  logic             rdValid,
  output var  logic             rdHit,
  output var  logic             wrIgnored
);
  import fdp_pkg::*;

  logic [7:0]                   base;
  logic [7:0]                   relOff;
  logic                         inRange;
  logic [4:0]                   idx;
  logic [0:FDP_ENTRIES-1][7:0]  romByte;
  logic [7:0]                   lookup;
  logic [7:0]                   next_rdData;

  // Two layouts, query offset two above
  assign base    = req.querySpace ? FDP_QUERY_BASE : FDP_DISC_BASE;
  assign relOff  = req.addr - base;
  assign inRange = relOff < FDP_ENTRY_CNT;
  assign idx     = inRange ? relOff[4:0] : 5'h00;

  genvar i;
  for (i = 0; i < FDP_ENTRIES; i++) begin : g_entry
    if (i == FDP_DUAL_IO_ENTRY) begin : g_lat
      assign romByte[i] = enhancedFastLatencyMode ? FDP_DUAL_IO_ENH : FDP_DUAL_IO_STD;
    end else begin : g_fix
      assign romByte[i] = FDP_TABLE[i];
    end
  end

  assign lookup      = romByte[idx];
  assign next_rdData = inRange ? lookup : FDP_FILL;

  // Read only: write data never stored
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData    <= FDP_RST_DATA;
      rdValid   <= 1'b0;
      rdHit     <= 1'b0;
      wrIgnored <= 1'b0;
    end else begin
      rdData    <= req.rd ? next_rdData : rdData;
      rdValid   <= req.rd;
      rdHit     <= req.rd && inRange;
      wrIgnored <= req.wr;
    end
  end

  // Checks
  sequence s_qrd(logic [7:0] a);
    req.rd && req.querySpace && req.addr == a;
  endsequence

  sequence s_drd(logic [7:0] a);
    req.rd && !req.querySpace && req.addr == a;
  endsequence

  property p_byte(logic [7:0] a, logic [7:0] d);
    @(posedge clk) disable iff (srst)
      s_qrd(a) |=> rdValid && rdHit && rdData == d;
  endproperty

  a_dual_out_cfg: assert property (p_byte(8'h0e, 8'h08))
    else $error("dual output config byte wrong");
  a_dual_out_op: assert property (p_byte(8'h0f, 8'h3b))
    else $error("dual output opcode wrong");

  a_dual_io_enh: assert property (@(posedge clk) disable iff (srst)
    s_qrd(8'h10) ##0 enhancedFastLatencyMode |=> rdData == 8'h80)
    else $error("dual io byte wrong in enhanced mode");
  a_dual_io_std: assert property (@(posedge clk) disable iff (srst)
    s_qrd(8'h10) ##0 !enhancedFastLatencyMode |=> rdData == 8'h04)
    else $error("dual io byte wrong in standard mode");

  a_dual_io_op: assert property (p_byte(8'h11, 8'hbb))
    else $error("dual io opcode wrong");
  a_mode_support: assert property (@(posedge clk) disable iff (srst)
    s_qrd(8'h12) |=> rdData == 8'hee && !rdData[4] && !rdData[0])
    else $error("all-mode support byte wrong");

  a_reserved_fill: assert property (@(posedge clk) disable iff (srst)
    req.rd && req.querySpace && req.addr inside {[8'h13:8'h17], [8'h1a:8'h1c]}
      |=> rdHit && rdData == 8'hff)
    else $error("reserved byte not all ones");

  a_dual_all_cfg: assert property (@(posedge clk) disable iff (srst)
    s_qrd(8'h18) |=> rdData[7:5] == 3'h7 && rdData[4:0] == 5'h1f)
    else $error("dual all cycle fields wrong");
  a_dual_all_op: assert property (p_byte(8'h19, 8'hff))
    else $error("dual all opcode wrong");

  a_quad_all_cfg: assert property (p_byte(8'h1d, 8'heb))
    else $error("quad all cycle byte wrong");
  a_quad_all_op: assert property (p_byte(8'h1e, 8'h00))
    else $error("quad all opcode wrong");

  a_erase1_op: assert property (p_byte(8'h1f, 8'hff))
    else $error("erase type 1 byte wrong");

  a_erase2_pair: assert property (@(posedge clk) disable iff (srst)
    s_qrd(8'h20) ##1 s_qrd(8'h21) |-> rdData == 8'h00 ##1 rdData == 8'hff)
    else $error("erase type 2 pair wrong");

  a_erase3_size: assert property (p_byte(8'h22, 8'h12))
    else $error("erase type 3 size wrong");
  a_erase3_op: assert property (p_byte(8'h23, 8'hd8))
    else $error("erase type 3 opcode wrong");

  a_erase4_pair: assert property (@(posedge clk) disable iff (srst)
    s_qrd(8'h24) ##1 s_qrd(8'h25) |-> rdData == 8'h00 ##1 rdData == 8'hff)
    else $error("erase type 4 pair wrong");

  a_layout_shift: assert property (@(posedge clk) disable iff (srst)
    s_drd(8'h0c) |=> rdHit && rdData == 8'h08)
    else $error("discovery layout not two below query layout");
  a_layout_edge: assert property (@(posedge clk) disable iff (srst)
    s_qrd(8'h0d) or s_drd(8'h24) |=> !rdHit && rdData == 8'hff)
    else $error("out of slice offset answered as hit");
  a_write_inert: assert property (@(posedge clk) disable iff (srst)
    req.wr && !req.rd |=> wrIgnored && !rdValid && $stable(rdData))
    else $error("write disturbed the read path");

  a_rsv_q13: assert property (p_byte(8'h13, 8'hff))
    else $error("reserved byte 13h wrong");
  a_rsv_q14: assert property (p_byte(8'h14, 8'hff))
    else $error("reserved byte 14h wrong");
  a_rsv_q15: assert property (p_byte(8'h15, 8'hff))
    else $error("reserved byte 15h wrong");
  a_rsv_q16: assert property (p_byte(8'h16, 8'hff))
    else $error("reserved byte 16h wrong");
  a_rsv_q17: assert property (p_byte(8'h17, 8'hff))
    else $error("reserved byte 17h wrong");
  a_rsv_q1a: assert property (p_byte(8'h1a, 8'hff))
    else $error("reserved byte 1Ah wrong");
  a_rsv_q1b: assert property (p_byte(8'h1b, 8'hff))
    else $error("reserved byte 1Bh wrong");
  a_rsv_q1c: assert property (p_byte(8'h1c, 8'hff))
    else $error("reserved byte 1Ch wrong");

  property p_dbyte(logic [7:0] a, logic [7:0] d);
    @(posedge clk) disable iff (srst)
      s_drd(a) |=> rdValid && rdHit && rdData == d;
  endproperty

  a_disc_dual_cfg: assert property (p_dbyte(8'h0c, 8'h08))
    else $error("discovery dual output config byte wrong");
  a_disc_dual_op: assert property (p_dbyte(8'h0d, 8'h3b))
    else $error("discovery dual output opcode wrong");

  a_disc_io_enh: assert property (@(posedge clk) disable iff (srst)
    s_drd(8'h0e) ##0 enhancedFastLatencyMode |=> rdData == 8'h80)
    else $error("discovery dual io byte wrong in enhanced mode");
  a_disc_io_std: assert property (@(posedge clk) disable iff (srst)
    s_drd(8'h0e) ##0 !enhancedFastLatencyMode |=> rdData == 8'h04)
    else $error("discovery dual io byte wrong in standard mode");
  a_disc_io_op: assert property (p_dbyte(8'h0f, 8'hbb))
    else $error("discovery dual io opcode wrong");

  a_disc_modes: assert property (p_dbyte(8'h10, 8'hee))
    else $error("discovery mode support byte wrong");

  a_disc_rsv_11: assert property (p_dbyte(8'h11, 8'hff))
    else $error("discovery reserved byte 11h wrong");
  a_disc_rsv_12: assert property (p_dbyte(8'h12, 8'hff))
    else $error("discovery reserved byte 12h wrong");
  a_disc_rsv_13: assert property (p_dbyte(8'h13, 8'hff))
    else $error("discovery reserved byte 13h wrong");
  a_disc_rsv_14: assert property (p_dbyte(8'h14, 8'hff))
    else $error("discovery reserved byte 14h wrong");
  a_disc_rsv_15: assert property (p_dbyte(8'h15, 8'hff))
    else $error("discovery reserved byte 15h wrong");
  a_disc_rsv_18: assert property (p_dbyte(8'h18, 8'hff))
    else $error("discovery reserved byte 18h wrong");
  a_disc_rsv_19: assert property (p_dbyte(8'h19, 8'hff))
    else $error("discovery reserved byte 19h wrong");
  a_disc_rsv_1a: assert property (p_dbyte(8'h1a, 8'hff))
    else $error("discovery reserved byte 1Ah wrong");

  a_disc_dall_cfg: assert property (p_dbyte(8'h16, 8'hff))
    else $error("discovery dual all cycle byte wrong");
  a_disc_dall_op: assert property (p_dbyte(8'h17, 8'hff))
    else $error("discovery dual all opcode wrong");

  a_disc_qall_cfg: assert property (p_dbyte(8'h1b, 8'heb))
    else $error("discovery quad all cycle byte wrong");
  a_disc_qall_op: assert property (p_dbyte(8'h1c, 8'h00))
    else $error("discovery quad all opcode wrong");

  a_disc_erase1_op: assert property (p_dbyte(8'h1d, 8'hff))
    else $error("discovery erase type 1 byte wrong");
  a_disc_erase2_size: assert property (p_dbyte(8'h1e, 8'h00))
    else $error("discovery erase type 2 size wrong");
  a_disc_erase2_op: assert property (p_dbyte(8'h1f, 8'hff))
    else $error("discovery erase type 2 opcode wrong");

  a_disc_erase3_size: assert property (p_dbyte(8'h20, 8'h12))
    else $error("discovery erase type 3 size wrong");
  a_disc_erase3_op: assert property (p_dbyte(8'h21, 8'hd8))
    else $error("discovery erase type 3 opcode wrong");
  a_disc_erase4_size: assert property (p_dbyte(8'h22, 8'h00))
    else $error("discovery erase type 4 size wrong");
  a_disc_erase4_op: assert property (p_dbyte(8'h23, 8'hff))
    else $error("discovery erase type 4 opcode wrong");

  a_valid_rise: assert property (@(posedge clk) disable iff (srst)
    req.rd |=> rdValid)
    else $error("read not answered in the next cycle");

  a_valid_idle: assert property (@(posedge clk) disable iff (srst)
    !req.rd |=> !rdValid)
    else $error("answer without a read");

  a_hit_idle: assert property (@(posedge clk) disable iff (srst)
    !req.rd |=> !rdHit)
    else $error("hit without a read");

  a_hit_valid: assert property (@(posedge clk) disable iff (srst)
    rdHit |-> rdValid)
    else $error("hit flag without valid answer");

  a_miss_fill: assert property (@(posedge clk) disable iff (srst)
    rdValid && !rdHit |-> rdData == 8'hff)
    else $error("miss answered with data other than all ones");

  a_data_hold: assert property (@(posedge clk) disable iff (srst)
    !req.rd |=> $stable(rdData))
    else $error("read data changed without a read");

  a_wr_flag: assert property (@(posedge clk) disable iff (srst)
    req.wr |=> wrIgnored)
    else $error("write attempt not flagged");

  a_wr_idle: assert property (@(posedge clk) disable iff (srst)
    !req.wr |=> !wrIgnored)
    else $error("write flag without a write");

  a_rd_wr_both: assert property (@(posedge clk) disable iff (srst)
    req.rd && req.wr |=> rdValid && wrIgnored)
    else $error("combined read and write not both answered");

  a_query_low: assert property (@(posedge clk) disable iff (srst)
    req.rd && req.querySpace && req.addr < 8'h0e |=> !rdHit && rdData == 8'hff)
    else $error("query offset below slice answered as hit");

  a_query_high: assert property (@(posedge clk) disable iff (srst)
    req.rd && req.querySpace && req.addr > 8'h25 |=> !rdHit && rdData == 8'hff)
    else $error("query offset above slice answered as hit");

  a_disc_low: assert property (@(posedge clk) disable iff (srst)
    req.rd && !req.querySpace && req.addr < 8'h0c |=> !rdHit && rdData == 8'hff)
    else $error("discovery offset below slice answered as hit");

  a_disc_high: assert property (@(posedge clk) disable iff (srst)
    req.rd && !req.querySpace && req.addr > 8'h23 |=> !rdHit && rdData == 8'hff)
    else $error("discovery offset above slice answered as hit");

  a_query_hit: assert property (@(posedge clk) disable iff (srst)
    req.rd && req.querySpace && req.addr inside {[8'h0e:8'h25]} |=> rdHit)
    else $error("query offset inside slice missed");

  a_disc_hit: assert property (@(posedge clk) disable iff (srst)
    req.rd && !req.querySpace && req.addr inside {[8'h0c:8'h23]} |=> rdHit)
    else $error("discovery offset inside slice missed");

  // Reset clears every output
  a_reset_clear: assert property (@(posedge clk)
    srst |=> rdData == 8'h00 && !rdValid && !rdHit && !wrIgnored)
    else $error("outputs not cleared by reset");

endmodule // fdp_param_rom

`default_nettype wire

// *** verification/fdp_host_model.sv ***
// Host model: issues one-byte table reads and write attempts.
// Assumes the ROM samples requests on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module fdp_host_model (
  input  wire logic              clk,
  output var  fdp_pkg::fdp_req_t req
);
  import fdp_pkg::*;

  initial req = '0;

  // One request for one cycle, then idle with scrambled address and data
  task automatic access(input logic r, input logic w, input logic q, input logic [7:0] a);
    @(posedge clk);
    req <= '{rd: r, wr: w, querySpace: q, addr: a, wrData: ~a};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, querySpace: !q, addr: ~a, wrData: a};
  endtask

  // Two reads on consecutive edges, then idle
  task automatic pair(input logic q, input logic [7:0] a);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, querySpace: q, addr: a, wrData: ~a};
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, querySpace: q, addr: a + 8'h01, wrData: a};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, querySpace: !q, addr: ~a, wrData: a};
  endtask
endmodule // fdp_host_model

`default_nettype wire

// *** verification/tb_flash_discovery_param_rom.sv ***
// Testbench for the discovery parameter ROM slice.
// Assumes a 50 ns clock and the host model as request source.
`timescale 1ns/1ps
`default_nettype none

module tb_flash_discovery_param_rom;
  import fdp_pkg::*;
  logic       clk       = 1'b0;
  logic       srst      = 1'b1;
  logic       enhMode   = 1'b0;
  fdp_req_t   req;
  logic [7:0] rdData;
  logic       rdValid;
  logic       rdHit;
  logic       wrIgnored;
  int         n_fail    = 0;
  int         cmp_count = 0;
  logic [7:0] expTab [24] = '{8'h08, 8'h3b, 8'h04, 8'hbb, 8'hee, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'heb,
    8'h00, 8'hff, 8'h00, 8'hff, 8'h12, 8'hd8, 8'h00, 8'hff};

  always #25 clk = ~clk;

  fdp_host_model u_fdp_host_model (.clk(clk), .req(req));

  fdp_param_rom u_fdp_param_rom (.clk(clk), .srst(srst), .req(req),
    .enhancedFastLatencyMode(enhMode), .rdData(rdData), .rdValid(rdValid),
    .rdHit(rdHit), .wrIgnored(wrIgnored));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic q, input logic [7:0] a, input logic [7:0] e, input logic hit);
    u_fdp_host_model.access(1'b1, 1'b0, q, a);
    #1;
    chk({7'h00, rdValid}, 8'h01);
    chk({7'h00, rdHit}, {7'h00, hit});
    chk(rdData, e);
  endtask

  task automatic sweep(input logic q, input logic e);
    @(posedge clk) enhMode <= e;
    for (int i = 0; i < 24; i++) begin
      rd(q, 8'(i + (q ? 14 : 12)), (i == 2 && e) ? 8'h80 : expTab[i], 1'b1);
    end
    $display("Test sweep layout %0d latency %0d done", q, e);
  endtask

  task automatic wr_test;
    rd(1'b1, 8'h23, 8'hd8, 1'b1);
    u_fdp_host_model.access(1'b0, 1'b1, 1'b1, 8'h22);
    #1;
    chk({7'h00, wrIgnored}, 8'h01); // write only flagged
    chk({7'h00, rdValid}, 8'h00); // write gives no read answer
    chk(rdData, 8'hd8); // read data held across write
    rd(1'b1, 8'h22, 8'h12, 1'b1); // byte unchanged
    chk({7'h00, wrIgnored}, 8'h00);
    u_fdp_host_model.access(1'b1, 1'b1, 1'b0, 8'h21);
    #1;
    chk({7'h00, wrIgnored}, 8'h01); // read and write together
    chk({6'h00, rdValid, rdHit}, 8'h03);
    chk(rdData, 8'hd8);
    $display("Test write attempt done");
  endtask

  task automatic pair_test(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    fork
      u_fdp_host_model.pair(1'b1, a);
      begin
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, rdValid}, 8'h01); // first answer
        chk(rdData, e0); // size byte
        @(posedge clk);
        #1;
        chk({7'h00, rdValid}, 8'h01); // second answer
        chk(rdData, e1); // opcode byte
      end
    join
    $display("Test back to back pair %h done", a);
  endtask

  task automatic edge_test;
    rd(1'b1, 8'h0d, 8'hff, 1'b0);
    rd(1'b1, 8'h26, 8'hff, 1'b0);
    rd(1'b0, 8'h24, 8'hff, 1'b0);
    rd(1'b0, 8'h0b, 8'hff, 1'b0);
    $display("Test outside slice done");
  endtask

  task automatic results;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(rdData, FDP_RST_DATA);
    chk({rdValid, rdHit, wrIgnored, 5'h00}, 8'h00);
    sweep(1'b1, 1'b0);
    sweep(1'b1, 1'b1); // enhanced latency value
    sweep(1'b0, 1'b1); // discovery layout offset
    sweep(1'b0, 1'b0); // standard latency value
    wr_test();
    pair_test(8'h20, 8'h00, 8'hff);
    pair_test(8'h24, 8'h00, 8'hff);
    edge_test();
    results();
  end

  initial begin
    #100000;
    n_fail++;
    results();
  end
endmodule // tb_flash_discovery_param_rom

`default_nettype wire
